/* File: cap_decode.sv */
// Claim decision for a memory access into the capability window
`timescale 1ns/1ps
module cap_decode
  import cap_regs_pkg::*;
(
  input  wire logic       hit_in,
  input  wire logic       lock_in,
  input  wire logic       mem_enable_in,
  input  wire logic [1:0] pstate_in,
  output logic            claim_out,
  output logic            forward_out
);
  always_comb begin
    claim_out   = hit_in && mem_enable_in && !lock_in && (pstate_in != PSTATE_D3);
    forward_out = hit_in && !mem_enable_in;
  end
endmodule

/* File: cap_regs_pkg.sv */
// Package with offsets, field layouts and reset values of the capability bank
package cap_regs_pkg;
  localparam logic [7:0]  CAP_LEN_OFF       = 8'h00;
  localparam logic [7:0]  IF_VER_OFF        = 8'h02;
  localparam logic [7:0]  STRUCT_OFF        = 8'h04;
  localparam logic [7:0]  CAPPAR_OFF        = 8'h08;
  localparam logic [7:0]  WINDOW_TOP        = 8'h1f;
  localparam logic [7:0]  CAP_LEN_VAL       = 8'h20;
  localparam logic [15:0] IF_VER_VAL        = 16'h0100;
  localparam logic [31:0] STRUCT_RST_SIX    = 32'h00103206;
  localparam logic [31:0] STRUCT_RST_FOUR   = 32'h00102204;
  localparam logic [31:0] CAPPAR_VAL        = 32'h00006871;
  localparam int          DEBUG_PORT_LSB    = 20;
  localparam int          COMPANION_LSB     = 12;
  localparam int          PER_COMP_LSB      = 8;
  localparam int          PORTS_LSB         = 0;
  localparam logic [3:0]  DEBUG_PORT_VAL    = 4'h1;
  localparam logic [3:0]  PER_COMP_VAL      = 4'h2;
  localparam logic [7:0]  EXT_CAPS_PTR_VAL  = 8'h68;
  localparam logic [3:0]  ISO_THRESH_VAL    = 4'h7;
  localparam logic [31:0] STRUCT_WR_MASK    = 32'h0000f00f;
  localparam logic [1:0]  PSTATE_D3         = 2'h3;
endpackage

/* File: cap_word_read.sv */
// Combinational word read mux of the capability bank
`timescale 1ns/1ps
module cap_word_read
  import cap_regs_pkg::*;
(
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] struct_in,
  output logic      [31:0] data_out
);
  always_comb begin
    if (addr_in[7:2] == CAP_LEN_OFF[7:2]) begin
      data_out = {IF_VER_VAL, 8'h00, CAP_LEN_VAL};
    end else if (addr_in[7:2] == STRUCT_OFF[7:2]) begin
      data_out = struct_in;
    end else if (addr_in[7:2] == CAPPAR_OFF[7:2]) begin
      data_out = CAPPAR_VAL;
    end else begin
      data_out = 32'h00000000;
    end
  end
endmodule

/* File: host_bus_model.sv */
// Host memory bus master issuing one-cycle software accesses
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        mclk_in,
  output logic             req_out,
  output logic             write_out,
  output logic             lock_out,
  output logic      [7:0]  addr_out,
  output logic      [3:0]  byte_en_out,
  output logic      [31:0] wdata_out
);
  initial begin
    {req_out, write_out, lock_out, addr_out, byte_en_out, wdata_out} = '0;
  end
  task automatic access(input logic w, input logic l, input logic [7:0] a,
                        input logic [3:0] b, input logic [31:0] d);
    @(posedge mclk_in);
    req_out     <= 1'b1;
    write_out   <= w;
    lock_out    <= l;
    addr_out    <= a;
    byte_en_out <= b;
    wdata_out   <= d;
  endtask
  // Released lines show no stale value
  task automatic idle();
    @(posedge mclk_in);
    req_out     <= 1'b0;
    write_out   <= ~write_out;
    lock_out    <= ~lock_out;
    addr_out    <= ~addr_out;
    byte_en_out <= ~byte_en_out;
    wdata_out   <= ~wdata_out;
  endtask
endmodule

/* File: tb.sv */
// Self-checking testbench of the capability register bank
`timescale 1ns/1ps
module tb
  import cap_regs_pkg::*;
;
  logic        mclk   = 1'b0;
  logic        resetn = 1'b0;
  logic        mem_en = 1'b1;
  logic        unl    = 1'b0;
  logic [1:0]  ps     = 2'h0;
  logic        srst   = 1'b0;
  logic        pend   = 1'b0;
  logic        req, wr, lk, claim, fwd, vld, hoff;
  logic [7:0]  addr;
  logic [3:0]  be, cc, pc;
  logic [31:0] wd, rd;
  logic [31:0] st     = STRUCT_RST_SIX;
  logic [43:0] q[$];
  int          fail_count = 0;
  int          tests_run  = 0;
  always #10 mclk = ~mclk;
  host_bus_model m (.mclk_in(mclk), .req_out(req), .write_out(wr), .lock_out(lk),
    .addr_out(addr), .byte_en_out(be), .wdata_out(wd));
  usb2_host_capability_regs #(.SIX_PORTS(1'b1)) i_dut (.mclk_in(mclk), .resetn_in(resetn),
    .req_in(req), .write_in(wr), .lock_in(lk), .addr_in(addr), .byte_en_in(be),
    .wdata_in(wd), .memory_space_enable_in(mem_en), .readonly_write_unlock_in(unl),
    .power_state_in(ps), .controller_soft_reset_in(srst), .claim_out(claim),
    .forward_out(fwd), .rdata_valid_out(vld), .rdata_out(rd),
    .companion_count_out(cc), .port_count_out(pc), .handoff_enable_out(hoff));
  task automatic print_verdict();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: outputs %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic w, input logic l, input logic [7:0] a,
                    input logic [3:0] b, input logic [31:0] d);
    logic        cl;
    logic [31:0] r;
    cl = a <= WINDOW_TOP && !l && ps != PSTATE_D3 && mem_en;
    r = a[7:2] == 6'h00 ? {IF_VER_VAL, 8'h00, CAP_LEN_VAL} : a[7:2] == 6'h01 ? st
      : a[7:2] == 6'h02 ? CAPPAR_VAL : 32'h0;
    if (cl && w && unl && a[7:2] == 6'h01) begin
      if (b[1]) st[15:12] = d[15:12];
      if (b[0] && d[3:0] != 4'h0) st[3:0] = d[3:0];
    end
    q.push_back({cl, a <= WINDOW_TOP && !mem_en, cl && !w, (cl && !w) ? r : 32'h0,
                 st[15:12], st[3:0], st[15:12] != 4'h0});
    m.access(w, l, a, b, d);
  endtask
  task automatic lv(input logic e, input logic u, input logic [1:0] p);
    m.idle();
    mem_en <= e;
    unl <= u;
    ps  <= p;
    #1;
  endtask
  // Answer slot one cycle after each request, silence otherwise
  always @(posedge mclk) begin
    if (pend && q.size() > 0)
      chk({claim, fwd, vld, rd, cc, pc, hoff}, q.pop_front());
    else
      chk({9'h0, claim, fwd, vld, rd}, 44'h0);
    pend = req && resetn;
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(93));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    for (int a = 0; a < 40; a += 4) op(1'b0, 1'b0, 8'(a), 4'hf, 32'h0);
    op(1'b1, 1'b0, STRUCT_OFF, 4'hf, 32'hffff_ffff);
    lv(1'b1, 1'b1, 2'h0);
    op(1'b1, 1'b0, CAPPAR_OFF, 4'hf, 32'hffff_ffff);
    op(1'b1, 1'b0, CAP_LEN_OFF, 4'hf, 32'hffff_ffff);
    for (int n = 2; n >= 0; n--) op(1'b1, 1'b0, STRUCT_OFF, 4'h2, 32'(n) << 12);
    op(1'b1, 1'b0, STRUCT_OFF, 4'h1, 32'h0);
    op(1'b1, 1'b0, STRUCT_OFF, 4'h3, 32'hffff_3f03);
    op(1'b0, 1'b0, STRUCT_OFF, 4'h0, 32'h0);
    repeat (60) begin
      lv(1'b1, 1'($urandom), 2'($urandom));
      op(1'($urandom), ($urandom_range(0, 3) == 0), 8'($urandom_range(0, 47)), 4'($urandom),
         $urandom);
      op(1'b0, 1'b0, STRUCT_OFF, 4'h0, 32'h0);
    end
    lv(1'b0, 1'b1, 2'h0);
    for (int a = 0; a < 48; a += 4) op(a[2], 1'b0, 8'(a), 4'hf, 32'h0000_5005);
    lv(1'b1, 1'b0, 2'h0);
    srst <= 1'b1;
    op(1'b0, 1'b0, STRUCT_OFF, 4'h0, 32'h0);
    m.idle();
    resetn <= 1'b0;
    st = STRUCT_RST_SIX;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    srst   <= 1'b0;
    op(1'b0, 1'b0, STRUCT_OFF, 4'h0, 32'h0);
    lv(1'b1, 1'b0, 2'h0);
    repeat (3) @(posedge mclk);
    print_verdict();
  end
endmodule

/* File: usb2_host_capability_regs.sv */
// Capability register bank of a USB 2.0 enhanced host controller
`timescale 1ns/1ps
module usb2_host_capability_regs
  import cap_regs_pkg::*;
#(
  parameter bit SIX_PORTS = 1'b1
)(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        req_in,
  input  wire logic        write_in,
  input  wire logic        lock_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [3:0]  byte_en_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        memory_space_enable_in,
  input  wire logic        readonly_write_unlock_in,
  input  wire logic [1:0]  power_state_in,
  input  wire logic        controller_soft_reset_in,
  output logic             claim_out,
  output logic             forward_out,
  output logic             rdata_valid_out,
  output logic      [31:0] rdata_out,
  output logic      [3:0]  companion_count_out,
  output logic      [3:0]  port_count_out,
  output logic             handoff_enable_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] structural_parameters;
    logic        claim;
    logic        forward;
    logic        rdata_valid;
    logic [31:0] rdata;
    logic        handoff;
  } state_s;

  localparam logic [31:0] STRUCT_RST = SIX_PORTS ? STRUCT_RST_SIX : STRUCT_RST_FOUR;

  state_s      cur;
  state_s      next_cur;
  logic        hit;
  logic        claim_now;
  logic        forward_now;
  logic [31:0] read_word;
  logic [31:0] bmask;
  logic [31:0] wr_mask;

  assign hit = req_in && (addr_in <= WINDOW_TOP);

  cap_decode u_decode (
    .hit_in        (hit),
    .lock_in       (lock_in),
    .mem_enable_in (memory_space_enable_in),
    .pstate_in     (power_state_in),
    .claim_out     (claim_now),
    .forward_out   (forward_now)
  );

  cap_word_read u_read (
    .addr_in   (addr_in),
    .struct_in (cur.structural_parameters),
    .data_out  (read_word)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_cur             = cur;
    bmask                = {{8{byte_en_in[3]}}, {8{byte_en_in[2]}},
                            {8{byte_en_in[1]}}, {8{byte_en_in[0]}}};
    wr_mask              = STRUCT_WR_MASK & bmask;
    next_cur.claim       = claim_now;
    next_cur.forward     = forward_now;
    next_cur.rdata_valid = claim_now && !write_in;
    next_cur.rdata       = (claim_now && !write_in) ? read_word : 32'h00000000;
    if (claim_now && write_in && readonly_write_unlock_in &&
        addr_in[7:2] == STRUCT_OFF[7:2]) begin
      // Companion and port count fields only
      next_cur.structural_parameters =
        (cur.structural_parameters & ~wr_mask) | (wdata_in & wr_mask);
      if (byte_en_in[0] && wdata_in[3:0] == 4'h0) begin
        // Zero port count is undefined; keep old value
        next_cur.structural_parameters[3:0] = cur.structural_parameters[3:0];
      end
    end
    next_cur.handoff = |next_cur.structural_parameters[COMPANION_LSB +: 4];
  end

  // ****************************************
  // Registers
  // ****************************************
  // Soft reset is not a reset here; only resetn_in initialises the bank
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cur.structural_parameters <= STRUCT_RST;
      cur.claim                 <= 1'b0;
      cur.forward               <= 1'b0;
      cur.rdata_valid           <= 1'b0;
      cur.rdata                 <= 32'h00000000;
      cur.handoff               <= |STRUCT_RST[COMPANION_LSB +: 4];
    end else begin
      cur <= next_cur;
    end
  end

  assign claim_out           = cur.claim;
  assign forward_out         = cur.forward;
  assign rdata_valid_out     = cur.rdata_valid;
  assign rdata_out           = cur.rdata;
  assign companion_count_out = cur.structural_parameters[COMPANION_LSB +: 4];
  assign port_count_out      = cur.structural_parameters[PORTS_LSB +: 4];
  assign handoff_enable_out  = cur.handoff;

  // ****************************************
  // Assertions
  // ****************************************
  locked_noclaim_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    req_in && lock_in |=> !claim_out) else $error("locked access claimed");
  d3_ignore_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    req_in && power_state_in == PSTATE_D3 |=> !claim_out) else $error("claimed in D3");
  mem_noclaim_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    req_in && !memory_space_enable_in |=> !claim_out) else $error("claimed while disabled");
  mem_forward_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    hit && !memory_space_enable_in |=> forward_out) else $error("not forwarded");
  softreset_keep_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    controller_soft_reset_in && !(req_in && write_in)
    |=> $stable(cur.structural_parameters)) else $error("soft reset altered bank");
  locked_write_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !readonly_write_unlock_in |=> $stable(cur.structural_parameters))
    else $error("write while locked");
  len_ver_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    claim_now && !write_in && addr_in[7:2] == 6'h00
    |=> rdata_valid_out && rdata_out == 32'h01000020) else $error("length or version");
  fixed_fields_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cur.structural_parameters[23:20] == 4'h1 && cur.structural_parameters[11:8] == 4'h2
    && cur.structural_parameters[31:24] == 8'h00 && cur.structural_parameters[19:16] == 4'h0
    && cur.structural_parameters[7:4] == 4'h0) else $error("fixed field changed");
  capparam_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    claim_now && !write_in && addr_in[7:2] == 6'h02
    |=> rdata_out == 32'h00006871) else $error("capability parameters wrong");
  ports_nonzero_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    port_count_out != 4'h0) else $error("port count zero");
  handoff_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    handoff_enable_out == (companion_count_out != 4'h0)) else $error("handoff mismatch");
  reset_val_a: assert property (@(posedge mclk_in)
    !resetn_in |=> cur.structural_parameters == STRUCT_RST) else $error("bad reset value");

  read_cov: cover property (@(posedge mclk_in) disable iff (!resetn_in) rdata_valid_out);
  write_cov: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    !$stable(cur.structural_parameters));
  forward_cov: cover property (@(posedge mclk_in) disable iff (!resetn_in) forward_out);
endmodule
